/* rtl/default_slave.sv */
// Default bus slave that answers transfers to unmapped memory.
// Assumes the address decoder drives hsel and the response multiplexer
// returns the shared bus ready on hready_in; one clock, synchronous reset.
`default_nettype none

module default_slave (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic hready_in,
    input wire logic [1:0] htrans,
    output logic hready_out,
    output logic [1:0] hresp
);

    // Decoded invalid-access flag and register next values.
    wire logic invalid;
    wire logic hready_d;
    dflt_slave_pkg::resp_type hresp_d;
    dflt_slave_pkg::state_type state_d;

    // Registered state and outputs.
    dflt_slave_pkg::state_type state_q;
    logic hready_q;
    dflt_slave_pkg::resp_type hresp_q;

    // Detects a data transfer aimed at unmapped memory.
    access_check u_check (
        .hsel(hsel),
        .hready_in(hready_in),
        .htrans(htrans),
        .invalid(invalid)
    );

    // Works out the response that the next data-phase cycle shows.
    response_next u_next (
        .invalid(invalid),
        .state_q(state_q),
        .state_d(state_d),
        .hready_d(hready_d),
        .hresp_d(hresp_d)
    );

    // Output registers load on the rising edge; reset gives OKAY ready.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= dflt_slave_pkg::RST_STATE;
            hready_q <= dflt_slave_pkg::RST_READY;
            hresp_q <= dflt_slave_pkg::RST_RESP;
        end else begin
            state_q <= state_d;
            hready_q <= hready_d;
            hresp_q <= hresp_d;
        end
    end

    // Outputs come straight from the flip-flops.
    assign hready_out = hready_q;
    assign hresp = hresp_q;

    // Checks on the response behaviour, all in the bus clock domain.
    default clocking chk_cb @(posedge mclk);
    endclocking

    default disable iff (!rst_n);

    // Helper: an idle or busy transfer handed to this slave.
    wire logic idle_kind;
    assign idle_kind = hsel && hready_in &&
        !dflt_slave_pkg::is_data_transfer(htrans);

    // Helper: a cycle in which the slave is not selected or the bus is stalled.
    wire logic unselected;
    assign unselected = !hsel || !hready_in;

    // First data-phase cycle of an error answer.
    sequence err_first_s;
        !hready_out && (hresp == dflt_slave_pkg::RESP_ERROR);
    endsequence

    // Second data-phase cycle of an error answer.
    sequence err_second_s;
        hready_out && (hresp == dflt_slave_pkg::RESP_ERROR);
    endsequence

    // A plain zero-wait OKAY cycle.
    sequence okay_s;
        hready_out && (hresp == dflt_slave_pkg::RESP_OKAY);
    endsequence

    // A flagged access in the address phase.
    sequence flagged_s;
        invalid;
    endsequence

    // Whole error answer following a flagged access.
    property error_answer_p;
        flagged_s |=> err_first_s ##1 err_second_s;
    endproperty

    // Idle or busy while not inside an error answer gives OKAY.
    property idle_okay_p;
        (idle_kind && hready_out) |=> okay_s;
    endproperty

    // Without a new flag, the wait state is followed by the second cycle.
    property idle_after_wait_p;
        (!hready_out && !invalid) |=> err_second_s;
    endproperty

    // Any data transfer handed over while selected gets ERROR.
    property data_error_p;
        (hsel && hready_in && dflt_slave_pkg::is_data_transfer(htrans)) |=>
            (hresp == dflt_slave_pkg::RESP_ERROR);
    endproperty

    // With nothing flagged and no wait pending, the next cycle is OKAY.
    property quiet_okay_p;
        (!invalid && hready_out) |=> okay_s;
    endproperty

    // Ready low lasts one cycle and was caused by a flagged access.
    property single_wait_p;
        !hready_out |-> $past(invalid) ##1 hready_out;
    endproperty

    // Error on the response has a flagged access one or two cycles back.
    property error_cause_p;
        (hresp == dflt_slave_pkg::RESP_ERROR) |->
            ($past(invalid) || $past(invalid, 2));
    endproperty

    // The flag never rises without its three conditions.
    property flag_cause_p;
        invalid |-> (hsel && hready_in &&
            dflt_slave_pkg::is_data_transfer(htrans));
    endproperty

    // The flag is raised whenever its three conditions meet.
    property flag_raise_p;
        (hsel && hready_in && dflt_slave_pkg::is_data_transfer(htrans))
            |-> invalid;
    endproperty

    // Ready falls exactly one clock after the flag rises.
    property reg_delay_p;
        $rose(invalid) |=> $fell(hready_out);
    endproperty

    // Leaving reset shows ready high and OKAY.
    property reset_state_p;
        $past(rst_n) == 1'h0 |-> okay_s;
    endproperty

    // No unselected access can start an error answer on its own.
    property unselected_quiet_p;
        (unselected && hready_out) |=> okay_s;
    endproperty

    // A data transfer taken in the second error cycle.
    sequence restart_s;
        flagged_s ##0 err_second_s;
    endsequence

    // A transfer taken in the second error cycle opens a fresh answer.
    property restart_p;
        restart_s |=> err_first_s ##1 err_second_s;
    endproperty

    // The second error cycle without a new flag is followed by OKAY.
    property error_end_p;
        (hready_out && !invalid && (hresp == dflt_slave_pkg::RESP_ERROR))
            |=> okay_s;
    endproperty

    // The wait state never shows anything but ERROR.
    property wait_error_p;
        !hready_out |-> (hresp == dflt_slave_pkg::RESP_ERROR);
    endproperty

    // An OKAY response always completes at once.
    property okay_ready_p;
        (hresp == dflt_slave_pkg::RESP_OKAY) |-> hready_out;
    endproperty

    // An unselected cycle never raises the flag.
    property unsel_flag_p;
        !hsel |-> !invalid;
    endproperty

    // A cycle in which the bus is still stalled never raises the flag.
    property stall_flag_p;
        !hready_in |-> !invalid;
    endproperty

    // Idle and busy transfers never raise the flag.
    property idle_flag_p;
        !dflt_slave_pkg::is_data_transfer(htrans) |-> !invalid;
    endproperty

    // While reset is applied the next cycle shows ready high and OKAY.
    property in_reset_p;
        disable iff (1'h0) !rst_n |=> okay_s;
    endproperty

    // The sequencer only ever holds one of its three states.
    property state_legal_p;
        state_q inside {dflt_slave_pkg::ST_OKAY,
            dflt_slave_pkg::ST_ERR_WAIT, dflt_slave_pkg::ST_ERR_LAST};
    endproperty

    // A flagged access loads the wait state into the sequencer.
    property flag_wait_p;
        flagged_s |=> (state_q == dflt_slave_pkg::ST_ERR_WAIT);
    endproperty

    // Ready falls for one cycle at a time and rises straight after.
    property ready_rise_p;
        $fell(hready_out) |=> $rose(hready_out);
    endproperty

    error_answer_a: assert property (error_answer_p)
        else $error("Error answer did not follow a flagged access.");

    idle_okay_a: assert property (idle_okay_p)
        else $error("Idle or busy transfer did not get zero-wait OKAY.");

    idle_after_wait_a: assert property (idle_after_wait_p)
        else $error("Second error cycle was lost after the wait state.");

    data_error_a: assert property (data_error_p)
        else $error("Data transfer to the default slave was not refused.");

    quiet_okay_a: assert property (quiet_okay_p)
        else $error("Response left OKAY without a flagged access.");

    single_wait_a: assert property (single_wait_p)
        else $error("Ready was low without cause or for too long.");

    error_cause_a: assert property (error_cause_p)
        else $error("Error shown without a recent flagged access.");

    flag_cause_a: assert property (flag_cause_p)
        else $error("Invalid flag raised without its conditions.");

    flag_raise_a: assert property (flag_raise_p)
        else $error("Invalid flag missed a data transfer.");

    reg_delay_a: assert property (reg_delay_p)
        else $error("Ready did not drop one cycle after the flag.");

    resp_legal_a: assert property (
        hresp == dflt_slave_pkg::RESP_OKAY ||
        hresp == dflt_slave_pkg::RESP_ERROR)
        else $error("Response carried a code other than OKAY or ERROR.");

    reset_state_a: assert property (reset_state_p)
        else $error("Outputs were not ready and OKAY after reset.");

    unselected_quiet_a: assert property (unselected_quiet_p)
        else $error("Unselected cycle produced a non-OKAY answer.");

    error_code_a: assert property (
        (state_q == dflt_slave_pkg::ST_OKAY) ==
        (hresp == dflt_slave_pkg::RESP_OKAY))
        else $error("Response code did not match the sequencer state.");

    restart_a: assert property (restart_p)
        else $error("Transfer in the second error cycle got no new answer.");

    error_end_a: assert property (error_end_p)
        else $error("Error answer did not end after its second cycle.");

    wait_error_a: assert property (wait_error_p)
        else $error("Wait state showed a response other than ERROR.");

    okay_ready_a: assert property (okay_ready_p)
        else $error("OKAY response was shown with ready low.");

    unsel_flag_a: assert property (unsel_flag_p)
        else $error("Invalid flag raised while not selected.");

    stall_flag_a: assert property (stall_flag_p)
        else $error("Invalid flag raised while the bus was stalled.");

    idle_flag_a: assert property (idle_flag_p)
        else $error("Invalid flag raised for an idle or busy transfer.");

    in_reset_a: assert property (in_reset_p)
        else $error("Reset did not leave ready high and OKAY.");

    state_legal_a: assert property (state_legal_p)
        else $error("Response sequencer reached an unused state code.");

    flag_wait_a: assert property (flag_wait_p)
        else $error("Flagged access did not load the wait state.");

    ready_rise_a: assert property (ready_rise_p)
        else $error("Ready stayed low for more than one cycle.");

endmodule : default_slave

`default_nettype wire

/* rtl/dflt_slave_pkg.sv */
// Shared constants and types for the default bus slave.
// Assumes the published transfer type and response encodings of the bus.
`default_nettype none

package dflt_slave_pkg;

    // Transfer type codes on the two-bit transfer type input.
    typedef enum logic [1:0] {
        TRANS_IDLE = 2'h0,
        TRANS_BUSY = 2'h1,
        TRANS_NONSEQ = 2'h2,
        TRANS_SEQ = 2'h3
    } trans_type;

    // Response codes; only OKAY and ERROR are ever produced here.
    typedef enum logic [1:0] {
        RESP_OKAY = 2'h0,
        RESP_ERROR = 2'h1,
        RESP_RETRY = 2'h2,
        RESP_SPLIT = 2'h3
    } resp_type;

    // Response sequencer states.
    typedef enum logic [1:0] {
        ST_OKAY = 2'h0,
        ST_ERR_WAIT = 2'h1,
        ST_ERR_LAST = 2'h2
    } state_type;

    // Values held in the output registers while reset is applied.
    localparam logic RST_READY = 1'h1;
    localparam resp_type RST_RESP = RESP_OKAY;
    localparam state_type RST_STATE = ST_OKAY;

    // True for transfer types that actually move data.
    function automatic logic is_data_transfer(input logic [1:0] trans);
        is_data_transfer = (trans == TRANS_NONSEQ) || (trans == TRANS_SEQ);
    endfunction : is_data_transfer

endpackage : dflt_slave_pkg

`default_nettype wire

/* rtl/access_check.sv */
// Flags a data transfer that is handed to the default slave.
// Assumes bus inputs are synchronous to the bus clock.
`default_nettype none

module access_check (
    input wire logic hsel,
    input wire logic hready_in,
    input wire logic [1:0] htrans,
    output logic invalid
);

    // Raised only in the last address-phase cycle of a real transfer.
    wire logic data_kind;

    assign data_kind = dflt_slave_pkg::is_data_transfer(htrans);
    assign invalid = hsel && hready_in && data_kind;

endmodule : access_check

`default_nettype wire

/* rtl/response_next.sv */
// Next-value logic for the response state and output registers.
// Assumes the caller holds the state and outputs in flip-flops.
`default_nettype none

module response_next (
    input wire logic invalid,
    input wire dflt_slave_pkg::state_type state_q,
    output dflt_slave_pkg::state_type state_d,
    output logic hready_d,
    output dflt_slave_pkg::resp_type hresp_d
);

    // A flagged access always opens a fresh error answer; otherwise the
    // wait state moves on to the second cycle and then back to OKAY.
    assign state_d = invalid ? dflt_slave_pkg::ST_ERR_WAIT :
        (state_q == dflt_slave_pkg::ST_ERR_WAIT) ?
        dflt_slave_pkg::ST_ERR_LAST : dflt_slave_pkg::ST_OKAY;

    // Ready drops only for the wait state of an error answer.
    assign hready_d =
        (state_d != dflt_slave_pkg::ST_ERR_WAIT);

    // Error stands for both data-phase cycles, otherwise OKAY.
    assign hresp_d = (state_d == dflt_slave_pkg::ST_OKAY) ?
        dflt_slave_pkg::RESP_OKAY : dflt_slave_pkg::RESP_ERROR;

endmodule : response_next

`default_nettype wire

/* testbench/bus_master_model.sv */
// Behavioural bus master seen through the decoder and response mux.
// Assumes the bench changes the commands just after a rising edge.
`default_nettype none

module bus_master_model (
    input wire logic mclk,
    input wire logic hready_out,
    input wire logic cmd_sel,
    input wire logic [1:0] cmd_trans,
    input wire logic cmd_stall,
    output var logic hsel = 1'h0,
    output var logic [1:0] htrans = 2'h0,
    output logic hready_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // A stall stands for another slave extending the bus transfer.
    logic stall_q = 1'h0;
    assign hready_in = hready_out & ~stall_q;

    // The address phase is held while the slave inserts a wait; the
    // stall is taken at the falling edge like every other bus input.
    always @(negedge mclk) begin
        stall_q <= cmd_stall;
        if (hready_out) begin
            hsel <= cmd_sel;
            htrans <= cmd_trans;
        end
    end
endmodule : bus_master_model

`default_nettype wire

/* testbench/default_slave_tb.sv */
// Self-checking bench for the default slave.
// Assumes the bus master model drives the select and transfer type.
`default_nettype none

module default_slave_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [1:0] OK = dflt_slave_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = dflt_slave_pkg::RESP_ERROR;
    localparam logic [1:0] ID = dflt_slave_pkg::TRANS_IDLE;
    localparam logic [1:0] NS = dflt_slave_pkg::TRANS_NONSEQ;
    localparam logic [1:0] SQ = dflt_slave_pkg::TRANS_SEQ;

    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic cmd_sel = 1'h0;
    logic [1:0] cmd_trans = 2'h0;
    logic cmd_stall = 1'h0;
    wire logic hsel;
    wire logic hready_in;
    wire logic [1:0] htrans;
    wire logic hready_out;
    wire logic [1:0] hresp;
    int fail_count = 0;
    int samples_checked = 0;

    // Design and its bus master.
    default_slave i_dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .hsel(hsel),
        .hready_in(hready_in),
        .htrans(htrans),
        .hready_out(hready_out),
        .hresp(hresp)
    );
    bus_master_model i_master (
        .mclk(mclk),
        .hready_out(hready_out),
        .cmd_sel(cmd_sel),
        .cmd_trans(cmd_trans),
        .cmd_stall(cmd_stall),
        .hsel(hsel),
        .htrans(htrans),
        .hready_in(hready_in)
    );

    // Clock of 100 ns period.
    initial begin
        forever #50 mclk = ~mclk;
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [1:0] seen, input logic [1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask : check

    // Sets the next command after a rising edge, returns at the fall.
    task automatic go(input logic s, input logic [1:0] t, input logic st);
        @(posedge mclk);
        cmd_sel <= s;
        cmd_trans <= t;
        cmd_stall <= st;
        @(negedge mclk);
    endtask : go

    // Compares both outputs as they stand at the falling edge.
    task automatic expect_out(input logic r, input logic [1:0] p);
        check({1'h0, hready_out}, {1'h0, r});
        check(hresp, p);
    endtask : expect_out

    // Selected idle and busy transfers get a zero-wait OKAY.
    task automatic test_idle;
        for (int k = 0; k < 2; k++) begin
            go(1'h1, 2'(k), 1'h0);
            go(1'h1, 2'(k), 1'h0);
            expect_out(1'h1, OK);
        end
    endtask : test_idle

    // Both data transfer kinds get the two-cycle error answer.
    task automatic test_error;
        for (int k = 2; k < 4; k++) begin
            go(1'h1, 2'(k), 1'h0);
            expect_out(1'h1, OK);
            go(1'h0, ID, 1'h0);
            expect_out(1'h0, ERR);
            go(1'h0, ID, 1'h0);
            expect_out(1'h1, ERR);
            go(1'h0, ID, 1'h0);
            expect_out(1'h1, OK);
        end
    endtask : test_error

    // Unselected or stalled data transfers raise no error.
    task automatic test_ignored;
        go(1'h0, NS, 1'h0);
        go(1'h0, NS, 1'h0);
        expect_out(1'h1, OK);
        go(1'h1, NS, 1'h1);
        go(1'h1, NS, 1'h1);
        expect_out(1'h1, OK);
        go(1'h0, ID, 1'h1);
        go(1'h0, ID, 1'h0);
        expect_out(1'h1, OK);
    endtask : test_ignored

    // A transfer in the second error cycle restarts the wait; reset then
    // overrides a transfer that would otherwise have been flagged.
    task automatic test_back;
        go(1'h1, NS, 1'h0);
        go(1'h1, SQ, 1'h0);
        expect_out(1'h0, ERR);
        go(1'h1, SQ, 1'h0);
        expect_out(1'h1, ERR);
        go(1'h0, ID, 1'h0);
        expect_out(1'h0, ERR);
        go(1'h0, ID, 1'h0);
        expect_out(1'h1, ERR);
        go(1'h1, NS, 1'h0);
        expect_out(1'h1, OK);
        rst_n = 1'h0;
        go(1'h0, ID, 1'h0);
        expect_out(1'h1, OK);
        rst_n = 1'h1;
        go(1'h0, ID, 1'h0);
        expect_out(1'h1, OK);
    endtask : test_back

    // Main sequence after three cycles of reset.
    initial begin
        repeat (3) @(negedge mclk);
        expect_out(1'h1, OK);
        rst_n = 1'h1;
        test_idle();
        test_error();
        test_ignored();
        test_back();
        print_verdict();
    end

    // Watchdog far beyond the few dozen cycles the tests need.
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end
endmodule : default_slave_tb

`default_nettype wire
